// ==== include/mgc_pkg.sv ====
// Package of register map, reset values and timing constants for the block.
package mgc_pkg;

  // ==========================================================================
  // Register offsets on the register port (byte addresses).
  // ==========================================================================
  localparam logic [11:0] ADDR_CURRENT_GAIN = 12'h1c0; // Current gain.
  localparam logic [11:0] ADDR_VOLTAGE_GAIN = 12'h1c4; // Voltage gain.
  localparam logic [11:0] ADDR_VOLTAGE_RMS = 12'h1c8; // Voltage RMS, read.
  localparam logic [11:0] ADDR_CURRENT_RMS = 12'h1cc; // Current RMS, read.
  localparam logic [11:0] ADDR_REAL_ENERGY = 12'h1d0; // Real energy, read.
  localparam logic [11:0] ADDR_REACT_ENERGY = 12'h1d4; // Reactive, read.
  localparam logic [11:0] ADDR_COMP_ANGLE_0 = 12'h1e0; // Angle, low band.
  localparam logic [11:0] ADDR_COMP_ANGLE_1 = 12'h1e4; // Angle, mid band.
  localparam logic [11:0] ADDR_COMP_ANGLE_2 = 12'h1e8; // Angle, high band.
  localparam logic [11:0] ADDR_LOW_THRESH = 12'h1ec; // Low threshold.
  localparam logic [11:0] ADDR_HIGH_THRESH = 12'h1f0; // High threshold.

  // ==========================================================================
  // Reset values and fixed-point layout.
  // ==========================================================================
  localparam logic [15:0] GAIN_UNITY = 16'h4000; // 1.0, 14 fraction bits.
  localparam int GAIN_FRAC_BITS = 14; // Gain fraction bits.
  localparam int ANGLE_FRAC_BITS = 16; // Angle fraction bits.
  localparam logic [15:0] ANGLE_RESET = 16'h0000; // No phase correction.
  localparam logic [15:0] THRESH_RESET = 16'h0000; // Thresholds cleared.
  localparam logic [31:0] ENERGY_RESET = 32'h0000_0000; // Energy cleared.

  // ==========================================================================
  // Result refresh timing.
  // ==========================================================================
  localparam int CLOCK_KHZ = 25000; // Clock rate in kHz.
  localparam int RESULT_SETTLE_MS = 2000; // Wait before a new gain shows.
  localparam int RESULT_SETTLE_CYCLES = RESULT_SETTLE_MS * CLOCK_KHZ;

  // Band chosen for phase compensation.
  typedef enum logic [1:0] {
    MGC_BAND_LOW = 2'b00,
    MGC_BAND_MID = 2'b01,
    MGC_BAND_HIGH = 2'b10
  } mgc_band_type;

endpackage

// ==== logic/mgc_calibration.sv ====
// Phase A gain and phase-angle calibration with energy accumulation.
`timescale 1ns/100ps

module mgc_calibration #(
  parameter int SETTLE_CYCLES = mgc_pkg::RESULT_SETTLE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [31:0] RAW_CURRENT_RMS,
  input wire logic [31:0] RAW_VOLTAGE_RMS,
  input wire logic [31:0] RAW_REAL_POWER,
  input wire logic [31:0] RAW_REACT_POWER,
  input wire logic POWER_VALID,
  output logic [31:0] PHASE_A_CURRENT_RMS,
  output logic [31:0] PHASE_A_VOLTAGE_RMS,
  output logic [15:0] ACTIVE_COMP_ANGLE,
  output logic CAPACITIVE
);

  // ==========================================================================
  // Elaboration check.
  // ==========================================================================
  // The refresh counter is 32 bits wide and must count at least one cycle.
  if (SETTLE_CYCLES < 1) begin : g_settle_check
    $error("mgc_calibration: SETTLE_CYCLES must be at least 1.");
  end

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic rst_meta; // First reset flop, read only by the second.
  logic rst_sync; // Released reset, active high while in reset.
  logic [15:0] current_gain; // Current gain code.
  logic [15:0] voltage_gain; // Voltage gain code.
  logic [15:0] phase_comp_angle_0; // Angle for the low band.
  logic [15:0] phase_comp_angle_1; // Angle for the middle band.
  logic [15:0] phase_comp_angle_2; // Angle for the high band.
  logic [15:0] low_current_threshold; // Boundary low to middle band.
  logic [15:0] high_current_threshold; // Boundary middle to high band.
  logic [31:0] phase_real_energy; // Accumulated real energy.
  logic [31:0] phase_reactive_energy; // Accumulated reactive energy.
  logic [31:0] scaled_current; // Current after gain.
  logic [31:0] scaled_voltage; // Voltage after gain.
  logic [31:0] refresh_count; // Cycles since the last RMS refresh.
  logic refresh_now; // RMS result refresh this cycle.
  mgc_pkg::mgc_band_type band; // Band selected by current level.
  logic [15:0] angle; // Angle of the selected band.
  logic signed [47:0] real_turn; // Reactive part rotated into real.
  logic signed [47:0] react_turn; // Real part rotated into reactive.
  logic [31:0] next_real; // Corrected real power sample.
  logic [31:0] next_react; // Corrected reactive power sample.

  // Decoded write strobe for one register address.
  function automatic logic hit(input logic [11:0] addr, input logic wr,
                               input logic [11:0] target);
    hit = wr && (addr == target);
  endfunction

  // ==========================================================================
  // Reset release.
  // ==========================================================================
  // The reset asserts at once but leaves through two flops so that no
  // register sees the release close to a clock edge.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================================
  // Writable registers.
  // ==========================================================================
  // Gains start at unity so an uncalibrated meter reads raw values. A code
  // with its top bit set is stored as written; the host must avoid it.
  always_ff @(posedge CLK or posedge rst_sync) begin
    if (rst_sync) begin
      current_gain <= mgc_pkg::GAIN_UNITY;
      voltage_gain <= mgc_pkg::GAIN_UNITY;
      phase_comp_angle_0 <= mgc_pkg::ANGLE_RESET;
      phase_comp_angle_1 <= mgc_pkg::ANGLE_RESET;
      phase_comp_angle_2 <= mgc_pkg::ANGLE_RESET;
      low_current_threshold <= mgc_pkg::THRESH_RESET;
      high_current_threshold <= mgc_pkg::THRESH_RESET;
    end else begin
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_CURRENT_GAIN)) begin
        current_gain <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_VOLTAGE_GAIN)) begin
        voltage_gain <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_COMP_ANGLE_0)) begin
        phase_comp_angle_0 <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_COMP_ANGLE_1)) begin
        phase_comp_angle_1 <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_COMP_ANGLE_2)) begin
        phase_comp_angle_2 <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_LOW_THRESH)) begin
        low_current_threshold <= REG_WDATA[15:0];
      end
      if (hit(REG_ADDR, REG_WR, mgc_pkg::ADDR_HIGH_THRESH)) begin
        high_current_threshold <= REG_WDATA[15:0];
      end
    end
  end

  // ==========================================================================
  // Gain scaling and RMS refresh.
  // ==========================================================================
  // One scaler for each channel; both use the same 2.14 format.
  mgc_gain_scale #(.WIDTH(32)) u_current_scale (
    .raw(RAW_CURRENT_RMS),
    .gain(current_gain),
    .scaled(scaled_current)
  );

  mgc_gain_scale #(.WIDTH(32)) u_voltage_scale (
    .raw(RAW_VOLTAGE_RMS),
    .gain(voltage_gain),
    .scaled(scaled_voltage)
  );

  assign refresh_now = (refresh_count == 32'(SETTLE_CYCLES - 1));

  // The RMS results refresh once per settle period, so a new gain is seen
  // no later than one period after the write, and the host reading early
  // simply sees the previous result.
  always_ff @(posedge CLK or posedge rst_sync) begin
    if (rst_sync) begin
      refresh_count <= 32'h0000_0000;
      PHASE_A_CURRENT_RMS <= 32'h0000_0000;
      PHASE_A_VOLTAGE_RMS <= 32'h0000_0000;
    end else begin
      if (refresh_now) begin
        refresh_count <= 32'h0000_0000;
        PHASE_A_CURRENT_RMS <= scaled_current;
        PHASE_A_VOLTAGE_RMS <= scaled_voltage;
      end else begin
        refresh_count <= refresh_count + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Band selection for phase compensation.
  // ==========================================================================
  // The upper half of the calibrated current RMS is compared against the
  // thresholds. With both thresholds zero the low band holds everywhere.
  always_comb begin
    if (low_current_threshold == mgc_pkg::THRESH_RESET &&
        high_current_threshold == mgc_pkg::THRESH_RESET) begin
      band = mgc_pkg::MGC_BAND_LOW;
    end else if (PHASE_A_CURRENT_RMS[31:16] < low_current_threshold) begin
      band = mgc_pkg::MGC_BAND_LOW;
    end else if (PHASE_A_CURRENT_RMS[31:16] < high_current_threshold) begin
      band = mgc_pkg::MGC_BAND_MID;
    end else begin
      band = mgc_pkg::MGC_BAND_HIGH;
    end
    case (band)
      mgc_pkg::MGC_BAND_LOW: begin
        angle = phase_comp_angle_0;
      end
      mgc_pkg::MGC_BAND_MID: begin
        angle = phase_comp_angle_1;
      end
      mgc_pkg::MGC_BAND_HIGH: begin
        angle = phase_comp_angle_2;
      end
      default: begin
        angle = phase_comp_angle_0;
      end
    endcase
  end

  // ==========================================================================
  // Phase rotation of the power samples.
  // ==========================================================================
  // Small-angle rotation: the angle is taken as its own sine, with cosine
  // one. A positive angle moves power toward inductive, a negative one
  // toward capacitive. Error grows with the angle, fine for a few degrees.
  always_comb begin
    real_turn = $signed(RAW_REACT_POWER) * $signed(angle);
    react_turn = $signed(RAW_REAL_POWER) * $signed(angle);
    next_real = RAW_REAL_POWER - real_turn[47:mgc_pkg::ANGLE_FRAC_BITS];
    next_react = RAW_REACT_POWER + react_turn[47:mgc_pkg::ANGLE_FRAC_BITS];
  end

  // ==========================================================================
  // Energy accumulation.
  // ==========================================================================
  // Sums are two's complement and wrap; the host reads often enough to
  // catch the wrap, as with any free-running energy counter.
  always_ff @(posedge CLK or posedge rst_sync) begin
    if (rst_sync) begin
      phase_real_energy <= mgc_pkg::ENERGY_RESET;
      phase_reactive_energy <= mgc_pkg::ENERGY_RESET;
    end else if (POWER_VALID) begin
      phase_real_energy <= phase_real_energy + next_real;
      phase_reactive_energy <=
        phase_reactive_energy + next_react;
    end
  end

  // ==========================================================================
  // Register read port and status outputs.
  // ==========================================================================
  // Read data is registered one cycle after the strobe; unmapped addresses
  // and unused upper bits read zero.
  always_ff @(posedge CLK or posedge rst_sync) begin
    if (rst_sync) begin
      REG_RDATA <= 32'h0000_0000;
      ACTIVE_COMP_ANGLE <= mgc_pkg::ANGLE_RESET;
      CAPACITIVE <= 1'b0;
    end else begin
      ACTIVE_COMP_ANGLE <= angle;
      CAPACITIVE <= phase_reactive_energy[31];
      if (REG_RD) begin
        case (REG_ADDR)
          mgc_pkg::ADDR_CURRENT_GAIN: REG_RDATA <= {16'h0000, current_gain};
          mgc_pkg::ADDR_VOLTAGE_GAIN: REG_RDATA <= {16'h0000, voltage_gain};
          mgc_pkg::ADDR_VOLTAGE_RMS: REG_RDATA <= PHASE_A_VOLTAGE_RMS;
          mgc_pkg::ADDR_CURRENT_RMS: REG_RDATA <= PHASE_A_CURRENT_RMS;
          mgc_pkg::ADDR_REAL_ENERGY:
            REG_RDATA <= phase_real_energy;
          mgc_pkg::ADDR_REACT_ENERGY:
            REG_RDATA <= phase_reactive_energy;
          mgc_pkg::ADDR_COMP_ANGLE_0:
            REG_RDATA <= {16'h0000, phase_comp_angle_0};
          mgc_pkg::ADDR_COMP_ANGLE_1:
            REG_RDATA <= {16'h0000, phase_comp_angle_1};
          mgc_pkg::ADDR_COMP_ANGLE_2:
            REG_RDATA <= {16'h0000, phase_comp_angle_2};
          mgc_pkg::ADDR_LOW_THRESH:
            REG_RDATA <= {16'h0000, low_current_threshold};
          mgc_pkg::ADDR_HIGH_THRESH:
            REG_RDATA <= {16'h0000, high_current_threshold};
          default: REG_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== logic/mgc_gain_scale.sv ====
// Unsigned RMS scaler that applies a 2.14 fixed-point gain with saturation.
`timescale 1ns/100ps
module mgc_gain_scale #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] raw,
  input wire logic [15:0] gain,
  output logic [WIDTH-1:0] scaled
);

  // ==========================================================================
  // Elaboration check.
  // ==========================================================================
  // The product slice below needs room above the fraction bits.
  if (WIDTH < 16) begin : g_width_check
    $error("mgc_gain_scale: WIDTH must be at least 16.");
  end

  logic [WIDTH+15:0] product; // Full product of value and gain.

  // ==========================================================================
  // Scaling.
  // ==========================================================================
  // Gain codes reach just under 4.0, so the result can overflow the field;
  // it saturates rather than wraps so a bad code never reads as a tiny value.
  always_comb begin
    product = raw * gain;
    if (|product[WIDTH+15:WIDTH+mgc_pkg::GAIN_FRAC_BITS]) begin
      scaled = '1;
    end else begin
      scaled = product[WIDTH+mgc_pkg::GAIN_FRAC_BITS-1:
                       mgc_pkg::GAIN_FRAC_BITS];
    end
  end

endmodule

// ==== testbench/mgc_host_model.sv ====
// Host controller model that drives the register port.
`timescale 1ns/100ps
module mgc_host_model (
  input wire logic clk,
  output logic [11:0] reg_addr,
  output logic reg_wr,
  output logic [31:0] reg_wdata,
  output logic reg_rd
);
  // The port idles with both strobes low from time zero.
  initial begin
    reg_addr = 12'h0;
    reg_wr = 1'b0;
    reg_wdata = 32'h0;
    reg_rd = 1'b0;
  end

  // One write or read; released lines flip so stale values never match.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = a < 12'h1c8 ? {d[31:16], 1'b0, d[14:0]} : d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
endmodule

// ==== testbench/mgc_properties.sv ====
// Checker of the calibration block's port relations, with its bind.
`timescale 1ns/100ps
module mgc_properties #(
  parameter int SETTLE_CYCLES = 16
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [31:0] RAW_CURRENT_RMS,
  input wire logic [31:0] RAW_VOLTAGE_RMS,
  input wire logic [31:0] RAW_REAL_POWER,
  input wire logic [31:0] RAW_REACT_POWER,
  input wire logic POWER_VALID,
  input wire logic [31:0] PHASE_A_CURRENT_RMS,
  input wire logic [31:0] PHASE_A_VOLTAGE_RMS,
  input wire logic [15:0] ACTIVE_COMP_ANGLE,
  input wire logic CAPACITIVE
);
  // ==========
  // Shadow state rebuilt from the ports.
  // ==========
  logic [15:0] sh [0:12]; // Writable words, indexed from the gain offset.
  logic [31:0] e_re; // Real energy sum.
  logic [31:0] e_im; // Reactive energy sum.
  wire [3:0] wi = REG_ADDR[5:2]; // Word index inside the map.
  wire wok = REG_WR && REG_ADDR[11:6] == 6'h07 && REG_ADDR[1:0] == 2'b0
    && (wi < 4'h2 || (wi > 4'h7 && wi < 4'hd)); // Writable word hit.
  wire [15:0] lvl = PHASE_A_CURRENT_RMS[31:16]; // Band compare level.
  wire [15:0] sel = (sh[11] == 16'h0 && sh[12] == 16'h0) || lvl < sh[11]
    ? sh[8] : lvl < sh[12] ? sh[9] : sh[10]; // Expected band angle.
  wire [47:0] cm = RAW_CURRENT_RMS * sh[0]; // Raw current times gain.
  wire [47:0] vm = RAW_VOLTAGE_RMS * sh[1]; // Raw voltage times gain.
  wire [31:0] ci = |cm[47:46] ? 32'hffffffff : cm[45:14]; // Saturated.
  wire [31:0] vi = |vm[47:46] ? 32'hffffffff : vm[45:14]; // Saturated.
  // The rotation uses the angle in force this cycle, not the late copy.
  wire signed [47:0] mq = $signed(RAW_REACT_POWER) *
    $signed(sel); // Q times angle.
  wire signed [47:0] mp = $signed(RAW_REAL_POWER) *
    $signed(sel); // P times angle.
  logic [31:0] age; // Cycles since the current RMS last changed.
  logic [31:0] last_cur; // Current RMS seen at the previous edge.

  // Writes land at the strobe edge; the gains leave reset at unity.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 13; i++) begin
        sh[i] <= i < 2 ? mgc_pkg::GAIN_UNITY : 16'h0;
      end
    end else if (wok) begin
      sh[wi] <= REG_WDATA[15:0];
    end
  end

  // Sums rotate each sample by the angle active in that cycle.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      e_re <= 32'h0;
      e_im <= 32'h0;
    end else if (POWER_VALID) begin
      e_re <= e_re + RAW_REAL_POWER - mq[47:16];
      e_im <= e_im + RAW_REACT_POWER + mp[47:16];
    end
  end

  // A refresh may only come once per settle period.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      age <= 32'h0;
      last_cur <= 32'h0;
    end else begin
      last_cur <= PHASE_A_CURRENT_RMS;
      age <= PHASE_A_CURRENT_RMS != last_cur ? 32'h1 : age + 32'h1;
    end
  end

  // ==========
  // Assertions.
  // ==========
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  property p_cur; $changed(PHASE_A_CURRENT_RMS) |->
    PHASE_A_CURRENT_RMS == $past(ci); endproperty
  a_cur: assert property (p_cur)
    else $error("current rms is not raw times gain");
  property p_vol; $changed(PHASE_A_VOLTAGE_RMS) |->
    PHASE_A_VOLTAGE_RMS == $past(vi); endproperty
  a_vol: assert property (p_vol)
    else $error("voltage rms is not raw times gain");
  property p_flat; sh[11] == 16'h0 && sh[12] == 16'h0 |=>
    ACTIVE_COMP_ANGLE == $past(sh[8]); endproperty
  a_flat: assert property (p_flat)
    else $error("cleared thresholds did not pick angle zero");
  property p_band; ACTIVE_COMP_ANGLE == $past(sel); endproperty
  a_band: assert property (p_band)
    else $error("wrong band angle");
  property p_real; REG_RD && REG_ADDR == mgc_pkg::ADDR_REAL_ENERGY |=>
    REG_RDATA == $past(e_re); endproperty
  a_real: assert property (p_real)
    else $error("real energy read mismatch");
  property p_react; REG_RD && REG_ADDR == mgc_pkg::ADDR_REACT_ENERGY |=>
    REG_RDATA == $past(e_im); endproperty
  a_react: assert property (p_react)
    else $error("reactive energy read mismatch");
  property p_cap; CAPACITIVE == $past(e_im[31]); endproperty
  a_cap: assert property (p_cap)
    else $error("capacitive flag not the reactive sign");
  property p_gain; REG_RD && REG_ADDR == mgc_pkg::ADDR_CURRENT_GAIN |=>
    REG_RDATA == {16'h0, $past(sh[0])}; endproperty
  a_gain: assert property (p_gain)
    else $error("current gain read mismatch");
  property p_settle; $changed(PHASE_A_CURRENT_RMS) |->
    age >= SETTLE_CYCLES; endproperty
  a_settle: assert property (p_settle)
    else $error("current rms refreshed inside the settle period");

  c_high: cover property (ACTIVE_COMP_ANGLE == sh[10] && sh[12] != 16'h0);
  c_cap: cover property ($rose(CAPACITIVE));
  c_read: cover property (REG_RD && REG_ADDR == mgc_pkg::ADDR_REAL_ENERGY);
endmodule

bind mgc_calibration mgc_properties #(.SETTLE_CYCLES(SETTLE_CYCLES))
  u_props (.CLK, .RST_B, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
  .REG_RDATA, .RAW_CURRENT_RMS, .RAW_VOLTAGE_RMS, .RAW_REAL_POWER,
  .RAW_REACT_POWER, .POWER_VALID, .PHASE_A_CURRENT_RMS,
  .PHASE_A_VOLTAGE_RMS, .ACTIVE_COMP_ANGLE, .CAPACITIVE);

// ==== testbench/tb_top.sv ====
// Self-checking bench of the phase A calibration block.
`timescale 1ns/100ps
`define CHK(got, want) \
  begin \
    cmp_count++; \
    if ((got) !== (want)) begin \
      err_count++; \
      $display("[FAIL] %0t: got %h want %h", $time, got, want); \
    end \
  end
module tb_top;
  localparam int SC = 16; // Short refresh period keeps the run brief.
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [11:0] REG_ADDR;
  logic REG_WR, REG_RD, CAPACITIVE;
  logic POWER_VALID = 1'b0;
  logic [31:0] REG_WDATA, REG_RDATA, PHASE_A_CURRENT_RMS, PHASE_A_VOLTAGE_RMS;
  logic [31:0] RAW_CURRENT_RMS = 0, RAW_VOLTAGE_RMS = 0;
  logic [31:0] RAW_REAL_POWER = 0, RAW_REACT_POWER = 0;
  logic [15:0] ACTIVE_COMP_ANGLE, g, ang;
  logic [31:0] exp_q [$]; // Expected read answers, oldest first.
  logic [31:0] ex, e_re, e_im;
  logic [15:0] pa [3] = '{16'h0011, 16'h0022, 16'h0033}; // Band angles.
  logic [15:0] lv [3] = '{16'h00ff, 16'h0100, 16'h0200}; // Edge levels.
  int err_count = 0;
  int cmp_count = 0;

  mgc_calibration #(.SETTLE_CYCLES(SC)) DUT (.CLK, .RST_B, .REG_ADDR,
    .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .RAW_CURRENT_RMS,
    .RAW_VOLTAGE_RMS, .RAW_REAL_POWER, .RAW_REACT_POWER, .POWER_VALID,
    .PHASE_A_CURRENT_RMS, .PHASE_A_VOLTAGE_RMS, .ACTIVE_COMP_ANGLE,
    .CAPACITIVE);
  mgc_host_model host (.clk(CLK), .reg_addr(REG_ADDR), .reg_wr(REG_WR),
    .reg_wdata(REG_WDATA), .reg_rd(REG_RD));

  initial forever #20 CLK = ~CLK;

  // Angle-times-value term of the rotation, arithmetic shift by 16.
  function automatic logic [31:0] rot(input logic [31:0] x);
    return 32'((longint'($signed(x)) * longint'($signed(ang))) >>> 16);
  endfunction

  // Reads note their expected answer before the strobe goes out.
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask

  // Answers settle after the strobe edge, so look at the next low phase.
  always @(posedge CLK) begin
    if (REG_RD === 1'b1) begin
      @(negedge CLK);
      ex = exp_q.pop_front();
      `CHK(REG_RDATA, ex)
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang is cut well past the few hundred cycles the tests need.
  initial begin
    #(40 * 5000);
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'h0b81));
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    RST_B = 1'b1;
    repeat (3) @(posedge CLK);
    // Whole map after reset, the five unmapped words included.
    for (int i = 0; i < 16; i++) begin
      rd(12'h1c0 + 12'(4 * i), i < 2 ? 32'h4000 : 32'h0);
    end
    $display("test reset done");
    RAW_CURRENT_RMS = {8'h0, 24'($urandom)} | 32'h10_0000;
    RAW_VOLTAGE_RMS = {8'h0, 24'($urandom)} | 32'h10_0000;
    g = 16'((64'(RAW_CURRENT_RMS + 32'($urandom_range(0, 2 ** 19))) << 14)
      / RAW_CURRENT_RMS);
    host.xfer(1'b1, mgc_pkg::ADDR_CURRENT_GAIN, {16'hffff, g});
    host.xfer(1'b1, mgc_pkg::ADDR_VOLTAGE_GAIN, 32'h3ea1);
    host.xfer(1'b1, mgc_pkg::ADDR_REAL_ENERGY, 32'h1234);
    rd(mgc_pkg::ADDR_CURRENT_GAIN, {16'h0, g});
    repeat (SC + 2) @(negedge CLK);
    e_re = 32'((64'(RAW_CURRENT_RMS) * g) >> 14);
    e_im = 32'((64'(RAW_VOLTAGE_RMS) * 16'h3ea1) >> 14);
    `CHK(PHASE_A_CURRENT_RMS, e_re)
    `CHK(PHASE_A_VOLTAGE_RMS, e_im)
    rd(mgc_pkg::ADDR_CURRENT_RMS, e_re);
    rd(mgc_pkg::ADDR_VOLTAGE_RMS, e_im);
    rd(mgc_pkg::ADDR_REAL_ENERGY, 32'h0);
    $display("test gain done");
    host.xfer(1'b1, mgc_pkg::ADDR_CURRENT_GAIN, 32'h4000);
    for (int i = 0; i < 3; i++) begin
      host.xfer(1'b1, mgc_pkg::ADDR_COMP_ANGLE_0 + 12'(4 * i), {16'h0, pa[i]});
    end
    for (int t = 0; t < 3; t++) begin
      host.xfer(1'b1, mgc_pkg::ADDR_LOW_THRESH, t == 1 ? 32'h100 : 32'h0);
      host.xfer(1'b1, mgc_pkg::ADDR_HIGH_THRESH, t == 1 ? 32'h200 : 32'h0);
      for (int i = 0; i < 3 && t < 2; i++) begin
        RAW_CURRENT_RMS = {lv[i], 16'($urandom)};
        repeat (SC + 2) @(negedge CLK);
        `CHK(ACTIVE_COMP_ANGLE, pa[t == 1 ? i : 0])
      end
    end
    $display("test band done");
    ang = -16'd572;
    host.xfer(1'b1, mgc_pkg::ADDR_COMP_ANGLE_0, {16'h0, ang});
    repeat (2) @(negedge CLK);
    e_re = 32'h0;
    e_im = 32'h0;
    repeat (8) begin
      RAW_REAL_POWER = $urandom_range(0, 32'h00ff_ffff);
      RAW_REACT_POWER = -32'($urandom_range(0, 65535));
      POWER_VALID = 1'b1;
      e_re += RAW_REAL_POWER - rot(RAW_REACT_POWER);
      e_im += RAW_REACT_POWER + rot(RAW_REAL_POWER);
      @(negedge CLK);
    end
    POWER_VALID = 1'b0;
    rd(mgc_pkg::ADDR_REAL_ENERGY, e_re);
    rd(mgc_pkg::ADDR_REACT_ENERGY, e_im);
    `CHK(CAPACITIVE, e_im[31])
    // The read monitor must take the last answer before the verdict.
    repeat (2) @(negedge CLK);
    `CHK(exp_q.size(), 0)
    $display("test energy done");
    summarize();
  end
endmodule
